// ==== ums_consts.svh ====
// register offsets, field positions, reset values, frame length and format write mask for the master spi block
`ifndef UMS_CONSTS_SVH
`define UMS_CONSTS_SVH

`define UMS_ADDR_W          3
`define UMS_OFF_DATA        3'h0
`define UMS_OFF_FLAG        3'h1
`define UMS_OFF_ENABLE      3'h2
`define UMS_OFF_FORMAT      3'h3
`define UMS_OFF_BAUD_LO     3'h4
`define UMS_OFF_BAUD_HI     3'h5

`define UMS_BIT_RX_DONE     7
`define UMS_BIT_TX_FIN      6
`define UMS_BIT_TX_EMPTY    5
`define UMS_BIT_RX_IE       7
`define UMS_BIT_TX_FIN_IE   6
`define UMS_BIT_TX_EMPTY_IE 5
`define UMS_BIT_RX_EN       4
`define UMS_BIT_TX_EN       3
`define UMS_BIT_MODE_HI     7
`define UMS_BIT_MODE_LO     6
`define UMS_BIT_ORDER       2
`define UMS_BIT_PHASE       1
`define UMS_BIT_POLARITY    0

`define UMS_RST_ENABLE      8'h00
`define UMS_RST_FORMAT      8'h06
`define UMS_RST_BAUD        12'h000
`define UMS_FRAME_BITS      4'h8
`define UMS_FORMAT_WMASK    8'hC7

`endif

// ==== ums_pkg.sv ====
// types shared by the master spi block
package ums_pkg;
  typedef enum logic [1:0] {
    UMS_MODE_ASYNC    = 2'b00,
    UMS_MODE_SYNC     = 2'b01,
    UMS_MODE_RESERVED = 2'b10,
    UMS_MODE_SPI      = 2'b11
  } ums_mode_t;

  typedef enum logic [1:0] {
    UMS_ST_IDLE  = 2'b00,
    UMS_ST_LEAD  = 2'b01,
    UMS_ST_TRAIL = 2'b10
  } ums_state_t;
endpackage

// ==== ums_sync.sv ====
// two-flop synchroniser for a pin input
`timescale 1ns/1ps
`default_nettype none
module ums_sync (
  input  wire logic mclk_i,   // system clock
  input  wire logic rst_n_i,  // synchronous reset, active low
  input  wire logic async_i,  // pin level
  output logic      sync_o    // synchronised level
);
  logic meta_q;

  // first flop feeds only the second
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      meta_q <= 1'b0;
      sync_o <= 1'b0;
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end
endmodule
`default_nettype wire

// ==== ums_baud.sv ====
// baud divider producing one-cycle half-period enable pulses
`timescale 1ns/1ps
`default_nettype none
module ums_baud #(
  parameter int DIV_W = 12
) (
  input  wire logic             mclk_i,   // system clock
  input  wire logic             rst_n_i,  // synchronous reset, active low
  input  wire logic             run_i,    // count while high, restart when low
  input  wire logic [DIV_W-1:0] div_i,    // divider setting
  output logic                  tick_o    // one pulse per half shift clock period
);
  logic [DIV_W-1:0] cnt_q;
  wire              at_end = (cnt_q >= div_i);

  // counts div+1 cycles per half period, giving f/(2(div+1))
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i || !run_i) begin
      cnt_q  <= '0;
      tick_o <= 1'b0;
    end else begin
      cnt_q  <= at_end ? '0 : cnt_q + 1'b1;
      tick_o <= at_end;
    end
  end
endmodule
`default_nettype wire

// ==== ums_master_spi.sv ====
// usart in master-only spi mode: register port, buffers, shifter and pin control
//
// The address map and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "ums_consts.svh"

// What this block does
// - frame error, overrun and parity flags always read zero
// - rx done flag is high exactly while receive buffer holds unread data
// - clearing receiver enable flushes the receive buffer
// - tx finished sets when frame shifted out and transmit buffer empty
// - tx finished clears on interrupt service or software writing one
// - tx empty flag high when buffer can take a byte, set after reset
// - receive interrupt needs its enable, global enable and rx done flag
// - tx finished interrupt needs its enable, global enable and flag
// - tx empty interrupt needs its enable, global enable and flag
// - receiver enable takes over the serial input pin
// - receiver alone performs no transfers; transmitter makes the clock
// - clearing transmitter enable waits until shifter and buffer are empty
// - transmitter drives serial output while enabled, else pin returns to port
// - mode field: 00 async, 01 sync, 10 reserved, 11 master spi
// - order, phase and polarity accepted in the same write as mode
// - order bit one shifts lsb first, zero shifts msb first
// - phase bit picks sampling on leading or trailing clock edge
// - polarity bit sets shift clock idle level and edge sense
// - transmitter double buffered, receiver has one extra buffer level
// - master only: no slave select, collision flag or double speed
// - modes 0 to 3 sample and set up on opposite clock edges
// - data register write starts a transfer when shifter is ready
// - on receive overflow the newest byte is discarded
module ums_master_spi
  import ums_pkg::*;
#(
  parameter int DIV_W = 12
) (
  input  wire logic                   mclk_i,           // system clock, 200 MHz
  input  wire logic                   rst_n_i,          // synchronous reset, active low
  input  wire logic [`UMS_ADDR_W-1:0] addr_i,           // register address
  input  wire logic [7:0]             wdata_i,          // write data
  input  wire logic                   wr_i,             // write strobe
  input  wire logic                   rd_i,             // read strobe
  output logic      [7:0]             rdata_o,          // read data, cycle after rd_i
  input  wire logic                   global_irq_en_i,  // global interrupt enable from cpu status
  input  wire logic                   tx_fin_ack_i,     // tx finished interrupt being serviced
  output logic                        irq_rx_done_o,    // receive complete request
  output logic                        irq_tx_fin_o,     // transmit complete request
  output logic                        irq_tx_empty_o,   // data register empty request
  input  wire logic                   serial_in_pin_i,  // serial data in from slave
  output logic                        serial_out_pin_o, // serial data out to slave
  output logic                        serial_out_oe_o,  // high while transmitter owns out pin
  output logic                        serial_in_own_o,  // high while receiver owns in pin
  output logic                        shift_clock_pin_o // shift clock to slave
);
  // ---------------- registers ----------------
  logic [7:0]       enable_q;
  logic [7:0]       format_q;
  logic [DIV_W-1:0] baud_q;
  logic             tx_active_q;  // transmitter in effect (drains after disable)
  logic             tx_fin_q;
  logic [7:0]       txbuf_q;
  logic             txbuf_full_q;
  logic [7:0]       rxbuf_q [2];  // two-level receive buffer
  logic [1:0]       rx_cnt_q;
  logic [7:0]       tsh_q;
  logic [7:0]       rsh_q;
  logic [3:0]       bit_cnt_q;
  ums_state_t       state_q;
  logic             sck_q;
  logic             sdo_q;

  // ---------------- decode ----------------
  wire wr_data   = wr_i && (addr_i == `UMS_OFF_DATA);
  wire wr_flag   = wr_i && (addr_i == `UMS_OFF_FLAG);
  wire wr_enable = wr_i && (addr_i == `UMS_OFF_ENABLE);
  wire wr_format = wr_i && (addr_i == `UMS_OFF_FORMAT);
  wire wr_blo    = wr_i && (addr_i == `UMS_OFF_BAUD_LO);
  wire wr_bhi    = wr_i && (addr_i == `UMS_OFF_BAUD_HI);
  wire rd_data   = rd_i && (addr_i == `UMS_OFF_DATA);

  wire       rx_en    = enable_q[`UMS_BIT_RX_EN];
  wire       tx_en    = enable_q[`UMS_BIT_TX_EN];
  wire       lsb_first = format_q[`UMS_BIT_ORDER];
  wire       cpha     = format_q[`UMS_BIT_PHASE];
  wire       cpol     = format_q[`UMS_BIT_POLARITY];
  wire       spi_mode = (ums_mode_t'(format_q[`UMS_BIT_MODE_HI:`UMS_BIT_MODE_LO]) == UMS_MODE_SPI);
  wire       rx_done  = (rx_cnt_q != 2'd0);
  wire       tx_empty = !txbuf_full_q;

  // ---------------- pin input ----------------
  logic sdi_s;
  ums_sync u_sync_sdi (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n_i),
    .async_i (serial_in_pin_i),
    .sync_o  (sdi_s)
  );

  // ---------------- baud ----------------
  logic busy;
  logic tick;
  assign busy = (state_q != UMS_ST_IDLE);
  ums_baud #(.DIV_W(DIV_W)) u_baud (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n_i),
    .run_i   (busy),
    .div_i   (baud_q),
    .tick_o  (tick)
  );

  // ---------------- shifter control ----------------
  // frame may load only in spi mode with transmitter in effect; receiver alone never clocks
  wire load     = !busy && txbuf_full_q && tx_active_q && spi_mode;
  wire lead_ev  = busy && tick && (state_q == UMS_ST_LEAD);
  wire trail_ev = busy && tick && (state_q == UMS_ST_TRAIL);
  wire sample   = cpha ? trail_ev : lead_ev;
  wire setup    = cpha ? lead_ev : trail_ev;
  wire last_bit = (bit_cnt_q == `UMS_FRAME_BITS - 4'd1);
  wire frame_end = trail_ev && last_bit;
  wire [7:0] rx_byte = lsb_first ? {sdi_s, rsh_q[7:1]} : {rsh_q[6:0], sdi_s};
  // with phase zero the last bit was already sampled on the leading edge
  wire [7:0] rx_word = cpha ? rx_byte : rsh_q;
  wire rx_push  = frame_end && rx_en;
  wire rx_pop   = rd_data && rx_done;
  wire tx_done_ev = frame_end && !txbuf_full_q;

  // first output bit of a loaded byte
  function automatic logic first_bit(input logic [7:0] b, input logic lsb);
    first_bit = lsb ? b[0] : b[7];
  endfunction

  // control registers; mode and format bits land in one write
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      enable_q <= `UMS_RST_ENABLE;
      format_q <= `UMS_RST_FORMAT;
      baud_q   <= DIV_W'(`UMS_RST_BAUD);
    end else begin
      if (wr_enable) enable_q <= wdata_i & 8'hF8;
      if (wr_format) format_q <= wdata_i & `UMS_FORMAT_WMASK;
      if (wr_blo)    baud_q[7:0] <= wdata_i;
      if (wr_bhi)    baud_q[DIV_W-1:8] <= wdata_i[DIV_W-9:0];
    end
  end

  // transmitter stays in effect until shifter and buffer drain
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      tx_active_q <= 1'b0;
    end else if (tx_en) begin
      tx_active_q <= 1'b1;
    end else if (!busy && !txbuf_full_q) begin
      tx_active_q <= 1'b0;
    end
  end

  // transmit buffer: second level in front of the shifter
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      txbuf_q      <= 8'h00;
      txbuf_full_q <= 1'b0;
    end else begin
      if (wr_data && tx_empty) begin
        txbuf_q      <= wdata_i;
        txbuf_full_q <= 1'b1;
      end else if (load) begin
        txbuf_full_q <= 1'b0;
      end
    end
  end

  // tx finished: set wins over both clears
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      tx_fin_q <= 1'b0;
    end else if (tx_done_ev) begin
      tx_fin_q <= 1'b1;
    end else if (tx_fin_ack_i || (wr_flag && wdata_i[`UMS_BIT_TX_FIN])) begin
      tx_fin_q <= 1'b0;
    end
  end

  // shift engine state and clock pin
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      state_q   <= UMS_ST_IDLE;
      bit_cnt_q <= 4'h0;
      sck_q     <= 1'b0;
    end else begin
      case (state_q)
        UMS_ST_IDLE: begin
          sck_q     <= cpol;
          bit_cnt_q <= 4'h0;
          if (load) state_q <= UMS_ST_LEAD;
        end
        UMS_ST_LEAD: begin
          if (tick) begin
            sck_q   <= !cpol;
            state_q <= UMS_ST_TRAIL;
          end
        end
        UMS_ST_TRAIL: begin
          if (tick) begin
            sck_q     <= cpol;
            bit_cnt_q <= bit_cnt_q + 4'h1;
            state_q   <= last_bit ? UMS_ST_IDLE : UMS_ST_LEAD;
          end
        end
        default: begin
          state_q <= UMS_ST_IDLE;
        end
      endcase
    end
  end

  // data shifting on setup and sample edges
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      tsh_q <= 8'h00;
      rsh_q <= 8'h00;
      sdo_q <= 1'b1;
    end else if (load) begin
      tsh_q <= txbuf_q;
      // with phase zero the first bit must stand before the leading edge
      sdo_q <= first_bit(txbuf_q, lsb_first);
    end else begin
      if (sample) begin
        rsh_q <= rx_byte;
        tsh_q <= lsb_first ? {1'b0, tsh_q[7:1]} : {tsh_q[6:0], 1'b0};
      end
      if (setup && cpha && (bit_cnt_q == 4'h0)) begin
        sdo_q <= first_bit(tsh_q, lsb_first);
      end else if (setup && !(cpha == 1'b0 && last_bit)) begin
        sdo_q <= lsb_first ? tsh_q[0] : tsh_q[7];
      end
      if (!tx_active_q) sdo_q <= 1'b1;
    end
  end

  // receive buffer of two levels; overflow drops the newest byte
  logic [1:0] rx_cnt_d;
  assign rx_cnt_d = rx_cnt_q - {1'b0, rx_pop};
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i || !rx_en) begin
      rx_cnt_q   <= 2'd0;
      rxbuf_q[0] <= 8'h00;
      rxbuf_q[1] <= 8'h00;
    end else begin
      if (rx_pop) rxbuf_q[0] <= rxbuf_q[1];
      if (rx_push && rx_cnt_d != 2'd2) begin
        rxbuf_q[rx_cnt_d[0]] <= rx_word;
        rx_cnt_q <= rx_cnt_d + 2'd1;
      end else begin
        rx_cnt_q <= rx_cnt_d;
      end
    end
  end

  // read mux; error flags and reserved bits are zero
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    case (addr_i)
      `UMS_OFF_DATA:    rd_mux = rxbuf_q[0];
      `UMS_OFF_FLAG:    rd_mux = {rx_done, tx_fin_q, tx_empty, 5'b00000};
      `UMS_OFF_ENABLE:  rd_mux = enable_q;
      `UMS_OFF_FORMAT:  rd_mux = format_q;
      `UMS_OFF_BAUD_LO: rd_mux = baud_q[7:0];
      `UMS_OFF_BAUD_HI: rd_mux = {{(16-DIV_W){1'b0}}, baud_q[DIV_W-1:8]};
      default:          rd_mux = 8'h00;
    endcase
  end

  // registered outputs
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      rdata_o           <= 8'h00;
      irq_rx_done_o     <= 1'b0;
      irq_tx_fin_o      <= 1'b0;
      irq_tx_empty_o    <= 1'b0;
      serial_out_pin_o  <= 1'b1;
      serial_out_oe_o   <= 1'b0;
      serial_in_own_o   <= 1'b0;
      shift_clock_pin_o <= 1'b0;
    end else begin
      rdata_o           <= rd_i ? rd_mux : 8'h00;
      irq_rx_done_o     <= enable_q[`UMS_BIT_RX_IE] && global_irq_en_i && rx_done;
      irq_tx_fin_o      <= enable_q[`UMS_BIT_TX_FIN_IE] && global_irq_en_i && tx_fin_q;
      irq_tx_empty_o    <= enable_q[`UMS_BIT_TX_EMPTY_IE] && global_irq_en_i && tx_empty;
      serial_out_pin_o  <= tx_active_q ? sdo_q : 1'b1;
      serial_out_oe_o   <= tx_active_q;
      serial_in_own_o   <= rx_en;
      shift_clock_pin_o <= busy ? sck_q : cpol;
    end
  end
endmodule
`default_nettype wire

// ==== ums_chk.sv ====
// port assertions for the master spi block
`timescale 1ns/1ps
`default_nettype none
`include "ums_consts.svh"
module ums_chk (
  input wire logic       mclk_i,            // system clock
  input wire logic       rst_n_i,           // reset, active low
  input wire logic [2:0] addr_i,            // register address
  input wire logic       wr_i,              // write strobe
  input wire logic       rd_i,              // read strobe
  input wire logic [7:0] rdata_o,           // read data
  input wire logic       global_irq_en_i,   // global enable
  input wire logic       irq_rx_done_o,     // rx request
  input wire logic       irq_tx_fin_o,      // tx finished request
  input wire logic       irq_tx_empty_o,    // tx empty request
  input wire logic       serial_out_pin_o,  // serial out
  input wire logic       serial_out_oe_o,   // out pin owned
  input wire logic       serial_in_own_o,   // in pin owned
  input wire logic       shift_clock_pin_o  // shift clock
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  // requests need the global enable one cycle earlier
  rx_irq_gate_a: assert property (irq_rx_done_o |-> $past(global_irq_en_i))
    else $error("rx request without global enable");
  fin_irq_gate_a: assert property (irq_tx_fin_o |-> $past(global_irq_en_i))
    else $error("tx finished request without global enable");
  empty_irq_gate_a: assert property (irq_tx_empty_o |-> $past(global_irq_en_i))
    else $error("tx empty request without global enable");
  // pin ownership, idle levels and zero error flag bits on flag reads
  out_idle_high_a: assert property (!serial_out_oe_o |-> serial_out_pin_o)
    else $error("serial out not idle while released");
  oe_from_write_a: assert property ($rose(serial_out_oe_o) |-> $past(wr_i, 2) || $past(wr_i, 3))
    else $error("out pin taken without a write");
  own_from_write_a: assert property ($rose(serial_in_own_o) |-> $past(wr_i) || $past(wr_i, 2))
    else $error("in pin taken without a write");
  clk_only_tx_a: assert property ($changed(shift_clock_pin_o) && !$past(wr_i) && !$past(wr_i, 2)
    |-> $past(serial_out_oe_o))
    else $error("shift clock moved without transmitter");
  err_bits_zero_a: assert property ($past(rd_i) && $past(addr_i) == `UMS_OFF_FLAG
    |-> rdata_o[4:0] == 5'h00)
    else $error("error flags not zero");
endmodule
bind ums_master_spi ums_chk ums_chk_i (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wr_i(wr_i),
  .rd_i(rd_i), .rdata_o(rdata_o), .global_irq_en_i(global_irq_en_i), .irq_rx_done_o(irq_rx_done_o),
  .irq_tx_fin_o(irq_tx_fin_o), .irq_tx_empty_o(irq_tx_empty_o), .serial_out_pin_o(serial_out_pin_o),
  .serial_out_oe_o(serial_out_oe_o), .serial_in_own_o(serial_in_own_o), .shift_clock_pin_o(shift_clock_pin_o));
`default_nettype wire

// ==== ums_slave.sv ====
// behavioural spi slave answering the master block
`timescale 1ns/1ps
`default_nettype none
module ums_slave (
  input  wire logic       sclk_i,   // shift clock
  input  wire logic       mosi_i,   // data from master
  input  wire logic       cpol_i,   // clock idle level
  input  wire logic       cpha_i,   // sample on trailing edge
  input  wire logic       clr_i,    // restart bit count
  input  wire logic [7:0] seed_i,   // first answer byte
  output logic            miso_o,   // data to master
  output logic [7:0]      got_o,    // last byte, wire order
  output int              frames_o  // frames done
);
  logic [7:0] rx_q;
  logic [7:0] tx_q;
  int         cnt;
  // restart framing
  always @(posedge clr_i) begin
    cnt = 0;
    tx_q = seed_i;
    miso_o = seed_i[7];
    frames_o = 0;
  end
  // sample and set up on opposite edges, answer byte counts up
  always @(sclk_i) begin
    if ((sclk_i != cpol_i) != cpha_i) begin
      rx_q = {rx_q[6:0], mosi_i};
      cnt++;
      if (cnt == 8) begin
        cnt = 0;
        got_o = rx_q;
        frames_o++;
        tx_q++;
      end
    end else miso_o = tx_q[7-cnt];
  end
endmodule
`default_nettype wire

// ==== ums_master_spi_tb_top.sv ====
// self-checking bench for the master spi block
`timescale 1ns/1ps
`default_nettype none
`include "ums_consts.svh"
module ums_master_spi_tb_top;
  localparam logic [2:0] a_dat = `UMS_OFF_DATA;
  localparam logic [2:0] a_flg = `UMS_OFF_FLAG;
  localparam logic [2:0] a_ena = `UMS_OFF_ENABLE;
  localparam logic [2:0] a_fmt = `UMS_OFF_FORMAT;
  logic       mclk_i, rst_n_i, wr_i, rd_i, gie, ack, clr, cpol, cpha;
  logic       miso, mosi, oe, own, sclk, irq_rx, irq_fin, irq_emp;
  logic [2:0] addr;
  logic [7:0] wdata, rdata, seed, got, d;
  int         frames, errors, checks, cyc;
  ums_master_spi ums_master_spi_i (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata), .global_irq_en_i(gie), .tx_fin_ack_i(ack),
    .irq_rx_done_o(irq_rx), .irq_tx_fin_o(irq_fin), .irq_tx_empty_o(irq_emp), .serial_in_pin_i(miso),
    .serial_out_pin_o(mosi), .serial_out_oe_o(oe), .serial_in_own_o(own), .shift_clock_pin_o(sclk));
  ums_slave ums_slave_i (.sclk_i(sclk), .mosi_i(mosi), .cpol_i(cpol), .cpha_i(cpha), .clr_i(clr),
    .seed_i(seed), .miso_o(miso), .got_o(got), .frames_o(frames));
  // compare and tasks for the register port
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task bus_wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge mclk_i); addr <= a; wdata <= v; wr_i <= 1'b1;
    @(posedge mclk_i); wr_i <= 1'b0;
  endtask
  task bus_rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge mclk_i); addr <= a; rd_i <= 1'b1;
    @(posedge mclk_i); rd_i <= 1'b0;
    #1 v = rdata;
  endtask
  task wait_flag(input int b);
    for (int n = 0; n < 400; n++) begin
      bus_rd(a_flg, d);
      if (d[b] === 1'b1) return;
    end
    chk(8'h00, 8'h01);
  endtask
  function automatic logic [7:0] rev(input logic [7:0] v);
    for (int k = 0; k < 8; k++) rev[k] = v[7-k];
  endfunction
  task set_fmt(input logic [7:0] f, input logic [7:0] s);
    bus_wr(a_fmt, f);
    cpol <= f[0]; cpha <= f[1]; seed <= s;
    repeat (3) @(posedge mclk_i);
    clr <= 1'b1;
    @(posedge mclk_i); clr <= 1'b0;
  endtask
  // reset values and an unmapped read
  task t_reset;
    bus_rd(a_flg, d); chk(d, 8'h20);
    bus_rd(a_ena, d); chk(d, `UMS_RST_ENABLE);
    bus_rd(a_fmt, d); chk(d, `UMS_RST_FORMAT);
    bus_rd(3'h7, d); chk(d, 8'h00);
  endtask
  // every mode and bit order, flags around each frame
  task t_modes;
    logic [7:0] f;
    for (int i = 0; i < 8; i++) begin
      f = 8'hC0 | 8'(i);
      set_fmt(f, 8'h3C + 8'(i));
      bus_wr(a_dat, 8'hA5 ^ 8'(i));
      wait_flag(`UMS_BIT_RX_DONE);
      chk(got, f[2] ? rev(8'hA5 ^ 8'(i)) : 8'hA5 ^ 8'(i));
      bus_rd(a_dat, d); chk(d, f[2] ? rev(8'h3C + 8'(i)) : 8'h3C + 8'(i));
      bus_rd(a_flg, d); chk(d, 8'h60);
      bus_wr(a_flg, 8'h40);
      bus_rd(a_flg, d); chk(d, 8'h20);
    end
  endtask
  // back to back writes, receive overflow
  task t_buffers;
    set_fmt(8'hC0, 8'h50);
    bus_wr(a_dat, 8'h11);
    bus_wr(a_dat, 8'h22);
    bus_rd(a_flg, d); chk(d[5], 1'b0);
    wait_flag(`UMS_BIT_TX_EMPTY);
    bus_wr(a_dat, 8'h33);
    wait_flag(`UMS_BIT_TX_FIN);
    chk(8'(frames), 8'h03);
    bus_rd(a_dat, d); chk(d, 8'h50);
    bus_rd(a_dat, d); chk(d, 8'h51);
    bus_rd(a_flg, d); chk(d[7], 1'b0);
    bus_wr(a_flg, 8'h40);
  endtask
  // interrupt requests and service
  task t_irq;
    bus_wr(a_ena, 8'hF8);
    repeat (3) @(posedge mclk_i);
    chk(irq_emp, 1'b0);
    gie <= 1'b1;
    repeat (3) @(posedge mclk_i);
    chk(irq_emp, 1'b1);
    bus_wr(a_dat, 8'h5A);
    wait_flag(`UMS_BIT_TX_FIN);
    chk(irq_rx, 1'b1);
    chk(irq_fin, 1'b1);
    @(posedge mclk_i); ack <= 1'b1;
    @(posedge mclk_i); ack <= 1'b0;
    repeat (2) @(posedge mclk_i);
    chk(irq_fin, 1'b0);
    bus_rd(a_dat, d);
    repeat (2) @(posedge mclk_i);
    chk(irq_rx, 1'b0);
    gie <= 1'b0;
  endtask
  // late transmitter disable, flush, receiver alone
  task t_disable;
    bus_wr(a_ena, 8'h18);
    bus_wr(a_dat, 8'h77);
    bus_wr(a_ena, 8'h10);
    repeat (4) @(posedge mclk_i);
    chk(oe, 1'b1);
    wait_flag(`UMS_BIT_TX_FIN);
    repeat (4) @(posedge mclk_i);
    chk({oe, mosi, own}, 3'b011);
    bus_wr(a_ena, 8'h00);
    bus_rd(a_flg, d); chk({d[7], own}, 2'b00);
    bus_wr(a_ena, 8'h10);
    bus_wr(a_dat, 8'h99);
    d = 8'(frames);
    repeat (300) @(posedge mclk_i);
    chk(8'(frames), d);
  endtask
  // clock
  initial begin
    mclk_i = 1'b0;
    forever #2.5 mclk_i = ~mclk_i;
  end
  // closing report
  task results;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // hang guard
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 40000) begin
      errors++;
      results;
    end
  end
  // main sequence
  initial begin
    {rst_n_i, wr_i, rd_i, gie, ack, clr, cpol, cpha} = 8'h00;
    {addr, wdata, seed} = 19'h0;
    {errors, checks, cyc} = {3{32'sd0}};
    repeat (12) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    t_reset;
    bus_wr(`UMS_OFF_BAUD_LO, 8'h0B);
    bus_wr(a_ena, 8'h18);
    t_modes;
    t_buffers;
    t_irq;
    t_disable;
    results;
  end
endmodule
`default_nettype wire
